/* File: hold_sweep_consts.svh */
/*
 * Sizing and offset constants for the max-hold and sweep command
 * unit. Assumes it is included by bare name from the type package; the
 * design modules use its macros; it holds definitions only.
 */
`ifndef HOLD_SWEEP_CONSTS_SVH
`define HOLD_SWEEP_CONSTS_SVH

// Number of frequency bins held in the max-hold array.
`define HOLD_BINS 16
// Width of a level word in hundredths of dBm.
`define LEVEL_W 16
// Depth of the transmit byte FIFO.
`define TX_DEPTH 16
// Sweep header length and the part that carries the step.
`define HDR_BYTES 32
`define HDR_STEP_BYTES 4
// Filler for the reserved header bytes.
`define HDR_RSVD_FILL 8'h00
// Reset value of the held step, in IEEE single format.
`define STEP_RESET 32'h00000000

`endif

/* File: hold_sweep_pkg.sv */
/*
 * Types shared by the max-hold and sweep command unit.
 * Assumes the constants header is available by bare name.
 */
package hold_sweep_pkg;
   `include "hold_sweep_consts.svh"

   // Replies that the unit reports to the command formatter.
   typedef enum logic [3:0] {
      RPL_NONE = 4'h0,
      RPL_HOLD_ENABLE_OK = 4'h1,
      RPL_HOLD_ENABLE_ON = 4'h2,
      RPL_HOLD_ENABLE_OFF = 4'h3,
      RPL_HOLD_PAUSE_OK = 4'h4,
      RPL_HOLD_PAUSE_ON = 4'h5,
      RPL_HOLD_PAUSE_OFF = 4'h6,
      RPL_HOLD_CLEAR_OK = 4'h7,
      RPL_SWEEP_DEFINE_OK = 4'h8,
      RPL_DEMOD_OFF = 4'h9
   } reply_e;

   // Byte emitter states, Gray coded along idle, high byte, header.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HI = 2'b01,
      ST_HDR = 2'b11
   } emit_e;

   typedef logic [`LEVEL_W-1:0] level_t;
endpackage : hold_sweep_pkg

/* File: tx_fifo.sv */
/*
 * Parameterised flip-flop FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module tx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic core_clk, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic in_valid, // Write request.
   output logic in_ready, // Space available.
   input wire logic [WIDTH-1:0] in_data, // Write data.
   output logic out_valid, // Data available.
   input wire logic out_ready, // Reader takes data.
   output logic [WIDTH-1:0] out_data, // Head of queue.
   output logic [$clog2(DEPTH):0] level // Words held.
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } fifo_s;

   fifo_s s_q;
   fifo_s s_d;
   logic push;
   logic pop;

   // Full and empty come from the held count, so they never lie.
   assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data = s_q.mem[s_q.rd];
   assign level = s_q.cnt;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Next-state logic for pointers, count and storage.
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr = s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = s_q.rd + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : tx_fifo

/* File: hold_sweep_unit.sv */
/*
 * Max-hold accumulator and sweep reply framer. Commands arrive decoded as
 * one-cycle pulses, levels arrive as a word stream, and the spectrum or
 * sweep data leave as a little-endian byte stream through a FIFO.
 * Assumes the command parser sends at most one command pulse per cycle
 * and that the byte stream is framed behind the textual acknowledge.
 */
`timescale 1ns/1ps
module hold_sweep_unit
   import hold_sweep_pkg::*;
(
   input wire logic core_clk, // 200 MHz system clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic hold_enable_cmd, // Hold enable command pulse.
   input wire logic hold_pause_cmd, // Hold pause command pulse.
   input wire logic cmd_on, // Parameter of the command: 1 is ON.
   input wire logic hold_clear_cmd, // Hold clear command pulse.
   input wire logic hold_enable_query, // Hold enable query pulse.
   input wire logic hold_pause_query, // Hold pause query pulse.
   input wire logic sweep_define_auto_step_cmd, // Sweep define, auto step.
   input wire logic sweep_define_step_cmd, // Sweep define with step.
   input wire logic [31:0] cmd_step, // Step parameter, IEEE single.
   input wire logic [31:0] best_step, // Best step for the RBW in use.
   input wire logic demod_status_query, // Demodulator query pulse.
   input wire logic analyzer_mode, // Level: analyzer mode selected.
   input wire logic sweep_mode, // Level: sweep mode selected.
   input wire logic setting_change, // Pulse: any setting changed.
   input wire logic tg_track_req, // Level: generator tracking wanted.
   input wire logic lvl_valid, // Level word valid.
   input wire logic [15:0] lvl_data, // Signed level, 0.01 dBm.
   input wire logic lvl_last, // Last word of spectrum or packet.
   output logic lvl_ready, // Unit accepts a level word.
   output logic tx_valid, // Output byte valid.
   output logic [7:0] tx_data, // Output byte.
   input wire logic tx_ready, // Link takes the byte.
   output logic reply_valid, // One-cycle reply strobe.
   output logic [3:0] reply_code, // Reply, as reply_e.
   output logic hold_enabled, // Hold function on.
   output logic hold_paused, // Hold pause on.
   output logic [31:0] sweep_step, // Step in use, IEEE single.
   output logic tracking_active, // Generator tracks the analyzer, never sweep mode.
   output logic tg_step // Pulse: advance the generator one step.
);

   // ****************************************************************
   // State
   // ****************************************************************

   typedef struct packed {
      emit_e st;
      logic hold_en;
      logic pause;
      logic fresh;
      logic [3:0] bin;
      logic an_prev;
      logic [`HOLD_BINS-1:0][`LEVEL_W-1:0] arr;
      logic [7:0] hi_byte;
      logic hdr_pend;
      logic [4:0] hdr_cnt;
      logic [31:0] step;
      logic rdy;
      logic rpl_v;
      reply_e rpl;
      logic track;
      logic tg_stb;
   } unit_s;

   unit_s s_q;
   unit_s s_d;

   logic push_v;
   logic [7:0] push_b;
   logic fifo_in_rdy;
   logic [$clog2(`TX_DEPTH):0] fifo_lvl;

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Signed comparison so that negative dBm levels order properly.
   function automatic level_t level_max(input level_t a, input level_t b);
      level_max = ($signed(a) > $signed(b)) ? a : b;
   endfunction : level_max

   // True for an IEEE single that is strictly greater than zero.
   function automatic logic step_positive(input logic [31:0] f);
      step_positive = !f[31] && (f[30:0] != 31'h0);
   endfunction : step_positive

   // Byte of the step word for a header position, low byte first.
   function automatic logic [7:0] step_byte(input logic [31:0] f,
                                            input logic [4:0] idx);
      step_byte = f[8*idx[1:0] +: 8];
   endfunction : step_byte

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   // One process decides commands, the hold array and the byte output.
   always_comb begin
      logic take;
      logic clr;
      logic upd;
      level_t held;
      level_t nxt;
      level_t out_w;
      logic [31:0] chosen;
      take = 1'b0;
      clr = 1'b0;
      upd = 1'b0;
      held = '0;
      nxt = '0;
      out_w = '0;
      chosen = '0;
      s_d = s_q;
      s_d.rpl_v = 1'b0;
      s_d.rpl = RPL_NONE;
      s_d.tg_stb = 1'b0;
      s_d.an_prev = analyzer_mode;
      push_v = 1'b0;
      push_b = '0;

      // Commands and queries; each answers with a one-cycle reply.
      if (hold_enable_cmd) begin
         s_d.hold_en = cmd_on;
         if (cmd_on) begin
            s_d.pause = 1'b0;
         end
         s_d.rpl_v = 1'b1;
         s_d.rpl = RPL_HOLD_ENABLE_OK;
      end else if (hold_pause_cmd) begin
         s_d.pause = cmd_on;
         s_d.rpl_v = 1'b1;
         s_d.rpl = RPL_HOLD_PAUSE_OK;
      end else if (hold_clear_cmd) begin
         s_d.rpl_v = 1'b1;
         s_d.rpl = RPL_HOLD_CLEAR_OK;
      end else if (hold_enable_query) begin
         s_d.rpl_v = 1'b1;
         s_d.rpl = s_q.hold_en ? RPL_HOLD_ENABLE_ON
                               : RPL_HOLD_ENABLE_OFF;
      end else if (hold_pause_query) begin
         s_d.rpl_v = 1'b1;
         s_d.rpl = s_q.pause ? RPL_HOLD_PAUSE_ON
                             : RPL_HOLD_PAUSE_OFF;
      end else if (demod_status_query) begin
         s_d.rpl_v = 1'b1;
         s_d.rpl = RPL_DEMOD_OFF;
      end else if (sweep_define_auto_step_cmd | sweep_define_step_cmd) begin
         // The explicit form wins only with a step above zero.
         if (sweep_define_step_cmd && step_positive(cmd_step)) begin
            chosen = cmd_step;
         end else begin
            chosen = best_step;
         end
         s_d.step = chosen;
         s_d.hdr_pend = 1'b1;
         s_d.rpl_v = 1'b1;
         s_d.rpl = RPL_SWEEP_DEFINE_OK;
      end

      // Clear events; a clear only marks the array stale, which is cheaper
      // than zeroing sixteen words and lets the next spectrum load as it comes.
      clr = hold_clear_cmd
            | (analyzer_mode & ~s_q.an_prev)
            | (analyzer_mode & setting_change);

      // Generator tracking follows the analyzer only, never the sweep.
      s_d.track = tg_track_req & analyzer_mode & ~sweep_mode;

      take = lvl_valid & s_q.rdy & (s_q.st == ST_IDLE);
      held = s_q.arr[s_q.bin];

      // Level word path: analyzer bins pass the hold logic, sweep words
      // are forwarded untouched.
      if (take) begin
         if (sweep_mode) begin
            out_w = lvl_data;
         end else begin
            upd = s_q.hold_en & ~s_q.pause;
            nxt = s_q.fresh ? lvl_data
                            : level_max(held, lvl_data);
            if (upd) begin
               s_d.arr[s_q.bin] = nxt;
            end
            if (!s_q.hold_en) begin
               out_w = lvl_data;
            end else if (s_q.pause) begin
               out_w = held;
            end else begin
               out_w = nxt;
            end
            s_d.tg_stb = s_q.track;
            if (lvl_last) begin
               s_d.bin = '0;
               if (upd) begin
                  s_d.fresh = 1'b0;
               end
            end else begin
               s_d.bin = s_q.bin + 4'h1;
            end
         end
         // Low byte now, high byte next cycle.
         push_v = 1'b1;
         push_b = out_w[7:0];
         s_d.hi_byte = out_w[15:8];
         s_d.st = ST_HI;
      end

      // A clear overrides the bookkeeping of the word taken with it.
      if (clr) begin
         s_d.fresh = 1'b1;
         s_d.bin = '0;
      end

      // Byte emitter.
      unique case (s_q.st)
         ST_IDLE: begin
            if (!take && s_q.hdr_pend) begin
               s_d.hdr_pend = 1'b0;
               s_d.hdr_cnt = '0;
               s_d.st = ST_HDR;
            end
         end
         ST_HI: begin
            push_v = 1'b1;
            push_b = s_q.hi_byte;
            if (fifo_in_rdy) begin
               s_d.st = ST_IDLE;
            end
         end
         ST_HDR: begin
            push_v = 1'b1;
            if (s_q.hdr_cnt < 5'(`HDR_STEP_BYTES)) begin
               push_b = step_byte(s_q.step, s_q.hdr_cnt);
            end else begin
               push_b = `HDR_RSVD_FILL;
            end
            if (fifo_in_rdy) begin
               s_d.hdr_cnt = s_q.hdr_cnt + 5'h1;
               if (s_q.hdr_cnt == 5'(`HDR_BYTES - 1)) begin
                  s_d.st = ST_IDLE;
               end
            end
         end
      endcase

      // Ready needs room for both bytes of a word; the margin of three
      // covers one push already in flight when this flop was set.
      s_d.rdy = (s_d.st == ST_IDLE) && !s_d.hdr_pend
                && (fifo_lvl <= ($clog2(`TX_DEPTH)+1)'(`TX_DEPTH - 3));
   end

   // ****************************************************************
   // Registers and outputs
   // ****************************************************************

   // State register.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.fresh <= 1'b1;
         s_q.step <= `STEP_RESET;
         s_q.rpl <= RPL_NONE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs taken from the state register.
   assign lvl_ready = s_q.rdy;
   assign reply_valid = s_q.rpl_v;
   assign reply_code = s_q.rpl;
   assign hold_enabled = s_q.hold_en;
   assign hold_paused = s_q.pause;
   assign sweep_step = s_q.step;
   assign tracking_active = s_q.track;
   assign tg_step = s_q.tg_stb;

   // ****************************************************************
   // Transmit buffer
   // ****************************************************************

   // The link can stall; back-pressure reaches lvl_ready through level.
   tx_fifo #(
      .WIDTH(8),
      .DEPTH(`TX_DEPTH)
   ) u_tx_fifo (
      .core_clk(core_clk),
      .srst(srst),
      .in_valid(push_v),
      .in_ready(fifo_in_rdy),
      .in_data(push_b),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data),
      .level(fifo_lvl)
   );
endmodule : hold_sweep_unit

/* File: hold_sweep_unit_chk.sv */
/* Assertions on the ports of the max-hold and sweep unit.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module hold_sweep_unit_chk (
   input wire logic core_clk, // Clock.
   input wire logic srst, // Reset.
   input wire logic hold_enable_cmd, // Pulse.
   input wire logic hold_pause_cmd, // Pulse.
   input wire logic cmd_on, // ON value.
   input wire logic hold_clear_cmd, // Pulse.
   input wire logic hold_enable_query, // Pulse.
   input wire logic hold_pause_query, // Pulse.
   input wire logic demod_status_query, // Pulse.
   input wire logic sweep_define_auto_step_cmd, // Pulse.
   input wire logic sweep_define_step_cmd, // Pulse.
   input wire logic [31:0] cmd_step, // Step.
   input wire logic [31:0] best_step, // Auto step.
   input wire logic sweep_mode, // Level.
   input wire logic tx_valid, // Byte valid.
   input wire logic [7:0] tx_data, // Byte.
   input wire logic tx_ready, // Byte taken.
   input wire logic reply_valid, // Strobe.
   input wire logic [3:0] reply_code, // Code.
   input wire logic hold_enabled, // Level.
   input wire logic hold_paused, // Level.
   input wire logic [31:0] sweep_step, // Step in use.
   input wire logic tracking_active // Level.
);
   // Lone commands only, so the priority order never muddles a check.
   logic one_cmd;
   assign one_cmd = $onehot({hold_enable_cmd, hold_pause_cmd,
      hold_clear_cmd, hold_enable_query, hold_pause_query,
      demod_status_query, sweep_define_auto_step_cmd,
      sweep_define_step_cmd});
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   property p_enable;
      one_cmd && hold_enable_cmd |=> reply_valid && reply_code == 4'h1
         && hold_enabled == $past(cmd_on);
   endproperty
   a_enable: assert property (p_enable) else $error("enable bad");
   property p_pause;
      one_cmd && hold_pause_cmd |=> reply_valid && reply_code == 4'h4
         && hold_paused == $past(cmd_on);
   endproperty
   a_pause: assert property (p_pause) else $error("pause bad");
   property p_en_query;
      one_cmd && hold_enable_query |=> reply_valid
         && reply_code == (hold_enabled ? 4'h2 : 4'h3);
   endproperty
   a_en_query: assert property (p_en_query) else $error("eq bad");
   property p_pa_query;
      one_cmd && hold_pause_query |=> reply_valid
         && reply_code == (hold_paused ? 4'h5 : 4'h6);
   endproperty
   a_pa_query: assert property (p_pa_query) else $error("pq bad");
   property p_clear;
      one_cmd && hold_clear_cmd |=> reply_valid && reply_code == 4'h7;
   endproperty
   a_clear: assert property (p_clear) else $error("clear bad");
   property p_demod;
      one_cmd && demod_status_query |=> reply_valid && reply_code == 4'h9;
   endproperty
   a_demod: assert property (p_demod) else $error("demod bad");
   property p_step;
      one_cmd && sweep_define_step_cmd && !cmd_step[31] && |cmd_step[30:0]
         |=> reply_code == 4'h8 && sweep_step == $past(cmd_step);
   endproperty
   a_step: assert property (p_step) else $error("step bad");
   property p_auto;
      one_cmd && sweep_define_auto_step_cmd
         |=> reply_code == 4'h8 && sweep_step == $past(best_step);
   endproperty
   a_auto: assert property (p_auto) else $error("auto bad");
   property p_track;
      sweep_mode |=> !tracking_active;
   endproperty
   a_track: assert property (p_track) else $error("track bad");
   property p_tx_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx bad");
   c_pause: cover property (one_cmd && hold_pause_cmd && cmd_on);
   c_step: cover property (one_cmd && sweep_define_step_cmd);
   c_stall: cover property (tx_valid && !tx_ready);
endmodule : hold_sweep_unit_chk

/* File: link_sink.sv */
/* Host side of the byte link: takes bytes into a queue.
   Assumes the bench reads the queue by hierarchical name. */
`timescale 1ns/1ps
module link_sink (
   input wire logic core_clk, // Clock.
   input wire logic srst, // Reset.
   input wire logic stall, // Bench holds the host busy.
   input wire logic tx_valid, // Byte valid.
   input wire logic [7:0] tx_data, // Byte.
   output logic tx_ready // Host takes a byte.
);
   logic [1:0] phase_q;
   logic [7:0] q[$];
   // Takes two bytes in three while stall is low and none while it is high, so the unit always meets a slow host.
   always @(posedge core_clk) begin
      if (srst) begin
         phase_q <= 2'h0;
         q.delete();
      end else begin
         phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
         if (tx_valid && tx_ready)
            q.push_back(tx_data);
      end
   end
   assign tx_ready = !stall && phase_q != 2'h2;
endmodule : link_sink

/* File: test_hold_sweep_unit.sv */
/* Self-checking bench for the max-hold and sweep unit.
   Assumes the checker and the host link model are compiled first. */
`timescale 1ns/1ps
module test_hold_sweep_unit;
   logic core_clk = 1'b0, srst = 1'b1, cmd_on = 1'b0, stall = 1'b0;
   logic analyzer_mode = 1'b0, sweep_mode = 1'b0, setting_change = 1'b0;
   logic tg_track_req = 1'b0, lvl_valid = 1'b0, lvl_last = 1'b0;
   logic [7:0] cmd_vec = 8'h00;
   logic [15:0] lvl_data = 16'h0000;
   logic [31:0] cmd_step = 32'h0, best_step = 32'h3f800000, v;
   logic lvl_ready, tx_valid, tx_ready, reply_valid, hold_enabled;
   logic hold_paused, tracking_active, tg_step;
   logic [7:0] tx_data;
   logic [3:0] reply_code;
   logic [31:0] sweep_step;
   int err_count = 0, checked = 0, steps = 0;
   // Rows: index, ON, enabled, paused, reply code, one nibble each.
   logic [19:0] crows[10] = '{20'h01101, 20'h30102, 20'h11114,
      20'h40115, 20'h01101, 20'h40106, 20'h00001, 20'h30003,
      20'h20007, 20'h50009};
   // Rows: action, ON, two words in, two words out.
   logic [71:0] srows[8] = '{72'h0_1_ff9c_0010_ff9c_0010,
      72'h8_0_ffce_0005_ffce_0010, 72'h1_1_0100_0100_ffce_0010,
      72'h1_0_0100_8000_0100_0010, 72'h0_0_0001_0002_0001_0002,
      72'h2_0_0002_0003_0002_0003, 72'h0_1_0005_0005_0005_0005,
      72'h7_0_8000_8000_8000_8000};
   // Rows: command index, step given, step expected.
   logic [67:0] wrows[3] = '{68'h7_41200000_41200000,
      68'h6_40000000_3f800000, 68'h7_00000000_3f800000};
   hold_sweep_unit dut (.core_clk, .srst, .hold_enable_cmd(cmd_vec[0]),
      .hold_pause_cmd(cmd_vec[1]), .cmd_on, .hold_clear_cmd(cmd_vec[2]),
      .hold_enable_query(cmd_vec[3]), .hold_pause_query(cmd_vec[4]),
      .demod_status_query(cmd_vec[5]),
      .sweep_define_auto_step_cmd(cmd_vec[6]),
      .sweep_define_step_cmd(cmd_vec[7]), .cmd_step, .best_step,
      .analyzer_mode, .sweep_mode, .setting_change, .tg_track_req,
      .lvl_valid, .lvl_data, .lvl_last, .lvl_ready, .tx_valid, .tx_data,
      .tx_ready, .reply_valid, .reply_code, .hold_enabled, .hold_paused,
      .sweep_step, .tracking_active, .tg_step);
   link_sink host (.core_clk, .srst, .stall, .tx_valid, .tx_data,
      .tx_ready);
   initial forever #2.5 core_clk = ~core_clk;
   // Counts generator step pulses for the tracking checks.
   always @(posedge core_clk) begin
      if (tg_step === 1'b1)
         steps++;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   // One command pulse; the reply stands only in the next cycle.
   task automatic pulse(input logic [3:0] idx, input logic on);
      @(posedge core_clk);
      cmd_vec <= 8'h01 << idx;
      cmd_on <= on;
      @(posedge core_clk);
      cmd_vec <= 8'h00;
      #1;
   endtask : pulse
   // Holds the word until the edge that finds the unit ready.
   task automatic send(input logic [15:0] w, input logic last);
      logic r;
      int n = 0;
      @(posedge core_clk);
      lvl_valid <= 1'b1;
      lvl_data <= w;
      lvl_last <= last;
      do begin
         #1;
         r = lvl_ready;
         @(posedge core_clk);
         n++;
      end while (r !== 1'b1 && n < 200);
      lvl_valid <= 1'b0;
      if (r !== 1'b1) begin
         err_count++;
         final_report();
      end
   endtask : send
   // Pops nb bytes from the host, assembled little-endian.
   task automatic take(input int nb, output logic [31:0] val);
      int n = 0;
      val = 32'h0;
      while (host.q.size() < nb && n < 500) begin
         @(posedge core_clk);
         n++;
      end
      if (host.q.size() < nb) begin
         err_count++;
         final_report();
      end
      for (int i = 0; i < nb; i++)
         val[8*i +: 8] = host.q.pop_front();
   endtask : take
   // Main sequence: reset, command table, hold spectra, sweep framing.
   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      #1;
      check({reply_valid, hold_enabled, hold_paused, tx_valid}, 4'h0);
      check(sweep_step, 32'h0);
      check(lvl_ready, 1'b1);
      $display("Test reset done");
      for (int i = 0; i < 10; i++) begin
         pulse(crows[i][19:16], crows[i][12]);
         check({reply_valid, reply_code}, {1'b1, crows[i][3:0]});
         check({hold_enabled, hold_paused}, {crows[i][8], crows[i][4]});
      end
      $display("Test command table done");
      @(posedge core_clk);
      analyzer_mode <= 1'b1;
      tg_track_req <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(tracking_active, 1'b1);
      // Commands go only between whole spectra.
      for (int i = 0; i < 8; i++) begin
         if (srows[i][71:68] == 4'h7) begin
            @(posedge core_clk);
            setting_change <= 1'b1;
            @(posedge core_clk);
            setting_change <= 1'b0;
         end else if (srows[i][71:68] != 4'h8)
            pulse(srows[i][71:68], srows[i][64]);
         send(srows[i][63:48], 1'b0);
         send(srows[i][47:32], 1'b1);
         take(2, v);
         check(v, srows[i][31:16]);
         take(2, v);
         check(v, srows[i][15:0]);
      end
      // High levels first, so a missed clear would show them again.
      send(16'h7fff, 1'b0);
      send(16'h7fff, 1'b1);
      take(4, v);
      check(v, 32'h7fff7fff);
      check(steps, 32'd18);
      // Leaving and re-entering analyzer mode clears the array.
      analyzer_mode <= 1'b0;
      @(posedge core_clk);
      analyzer_mode <= 1'b1;
      send(16'h0001, 1'b0);
      send(16'h0002, 1'b1);
      take(4, v);
      check(v, 32'h00020001);
      $display("Test max hold done");
      @(posedge core_clk);
      analyzer_mode <= 1'b0;
      sweep_mode <= 1'b1;
      // No smart detector, generator or window command is ever sent;
      // the demodulator only gets its status query, in the command table.
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         cmd_step <= wrows[i][63:32];
         stall <= (i == 0);
         pulse(wrows[i][67:64], 1'b0);
         check({reply_valid, reply_code}, 5'h18);
         check(sweep_step, wrows[i][31:0]);
         check(tracking_active, 1'b0);
         // The stalled host lets the header fill the buffer.
         repeat (24) @(posedge core_clk);
         check({lvl_ready, host.q.size() == 0}, {1'b0, i == 0});
         stall <= 1'b0;
         take(4, v);
         check(v, wrows[i][31:0]);
         // Reserved bytes are drained and not judged.
         repeat (7) take(4, v);
      end
      send(16'hfe0c, 1'b0);
      send(16'h1234, 1'b1);
      take(4, v);
      check(v, 32'h1234fe0c);
      $display("Test sweep framing done");
      final_report();
   end
endmodule : test_hold_sweep_unit
bind hold_sweep_unit hold_sweep_unit_chk chk (.core_clk, .srst,
   .hold_enable_cmd, .hold_pause_cmd, .cmd_on, .hold_clear_cmd,
   .hold_enable_query, .hold_pause_query, .demod_status_query,
   .sweep_define_auto_step_cmd, .sweep_define_step_cmd, .cmd_step,
   .best_step, .sweep_mode, .tx_valid, .tx_data, .tx_ready, .reply_valid,
   .reply_code, .hold_enabled, .hold_paused, .sweep_step,
   .tracking_active);
